//--- pkg/prw_cfg.svh
`ifndef PRW_CFG_SVH
`define PRW_CFG_SVH
`define PRW_OFS_IN_A      8'h00
`define PRW_OFS_IN_B      8'h01
`define PRW_OFS_MODE_A    8'h02
`define PRW_OFS_MODE_B    8'h03
`define PRW_OFS_OUT_A     8'h04
`define PRW_OFS_OUT_B     8'h05
`define PRW_OFS_DIR_A     8'h06
`define PRW_OFS_DIR_B     8'h07
`define PRW_OFS_DRV_A     8'h08
`define PRW_OFS_DRV_B     8'h09
`define PRW_OFS_IMC_A     8'h0a
`define PRW_OFS_IMC_B     8'h0b
`define PRW_OFS_OE_A      8'h0c
`define PRW_OFS_OE_B      8'h0d
`define PRW_OFS_IN_C      8'h10
`define PRW_OFS_IN_D      8'h11
`define PRW_OFS_OUT_C     8'h12
`define PRW_OFS_OUT_D     8'h13
`define PRW_OFS_DIR_C     8'h14
`define PRW_OFS_DIR_D     8'h15
`define PRW_OFS_DRV_C     8'h16
`define PRW_OFS_DRV_D     8'h17
`define PRW_OFS_IMC_C     8'h18
`define PRW_OFS_OE_C      8'h1a
`define PRW_OFS_OE_D      8'h1b
`define PRW_OFS_OMC_AB    8'h20
`define PRW_OFS_OMC_BC    8'h21
`define PRW_OFS_MASK_AB   8'h22
`define PRW_OFS_MASK_BC   8'h23
`define PRW_OFS_PWR0      8'hb0
`define PRW_OFS_PWR2      8'hb4
`define PRW_OFS_PROT_MAIN 8'hc0
`define PRW_OFS_PROT_SEC  8'hc2
`define PRW_OFS_TEST_EN   8'hc7
`define PRW_OFS_PAGE      8'he0
`define PRW_OFS_MAP       8'he2
`define PRW_RST_BYTE      8'h00
`define PRW_UNMAPPED_RD   8'hff
`define PRW_PWR0_SPEED    3
`define PRW_BYTE_W        8
`define PRW_NUM_PORTS     4
`endif

//--- pkg/prw_pkg.sv
package prw_pkg;
   typedef logic [7:0] prw_byte_t;
   typedef struct packed {
      logic      rd;
      logic      wr;
      prw_byte_t ofs;
      prw_byte_t wdata;
   } prw_req_s;
   typedef struct packed {
      prw_byte_t in_a;
      prw_byte_t in_b;
      prw_byte_t in_c;
      prw_byte_t in_d;
   } prw_pins_s;
endpackage

//--- hdl/prw_port_window.sv
// Operation
// - all registers decode inside one 256-byte window offset from the window select base.
// - pin-input registers at 00,01,10,11 return the synchronised pin levels of ports a-d.
// - output registers at 04,05,12,13 hold written data and drive it on output pins.
// - direction registers at 06,07,14,15 make each pin an input or an output.
// - ports a and b alone have mode registers at 02,03 choosing i/o or latched address.
// - driver-type registers at 08,09,16,17 choose cmos, open drain or fast slew.
// - drive-enable state registers at 0c,0d,1a,1b return each pin driver's enable.
// - output cell registers at 20,21 read the cells and a write loads them directly.
// - mask bits at 22,23 stop writes from changing the matching output cells.
// - protection status at c0,c2 is read only and writes there are ignored.
// - in latched address mode ports a and b show a3-a0 low and a7-a4 high.
// - the memory map register at e2 places each memory area in program, data or both.
// - clearing the speed bit of power control first makes the logic array hold its outputs.
`include "prw_cfg.svh"
module prw_port_window (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire logic               ce_in,
   // microcontroller bus
   input  wire logic               window_select_in,
   input  wire prw_pkg::prw_req_s  req_in,
   input  wire logic [7:0]         latched_addr_in,
   output logic [7:0]              rdata_out,
   output logic                    rdata_valid_out,
   // pins
   input  wire prw_pkg::prw_pins_s pins_in,
   input  wire prw_pkg::prw_byte_t input_cells_a_in,
   input  wire prw_pkg::prw_byte_t input_cells_b_in,
   input  wire prw_pkg::prw_byte_t input_cells_c_in,
   input  wire prw_pkg::prw_byte_t main_protect_in,
   input  wire prw_pkg::prw_byte_t secondary_protect_in,
   input  wire prw_pkg::prw_byte_t cells_next_ab_in,
   input  wire prw_pkg::prw_byte_t cells_next_bc_in,
   input  wire logic               cells_clock_in,
   output logic [31:0]             pin_out,
   output logic [31:0]             pin_oe_n_out,
   output logic [31:0]             pin_drive_type_out,
   // system controls
   output logic [7:0]              cells_ab_out,
   output logic [7:0]              cells_bc_out,
   output logic                    array_sleep_out,
   output logic [7:0]              power_second_out,
   output logic [7:0]              test_port_enable_out,
   output logic [7:0]              page_out,
   output logic [7:0]              memory_space_map_out
);
   import prw_pkg::*;

   prw_pins_s pins_meta_reg;
   prw_pins_s pins_sync_reg;
   prw_byte_t imc_meta_reg [3];
   prw_byte_t imc_sync_reg [3];
   prw_byte_t prot_meta_reg [2];
   prw_byte_t prot_sync_reg [2];

   prw_byte_t out_reg    [4];
   prw_byte_t dir_reg    [4];
   prw_byte_t drv_reg    [4];
   prw_byte_t mode_reg   [2];
   prw_byte_t omc_ab_reg;
   prw_byte_t omc_bc_reg;
   prw_byte_t mask_ab_reg;
   prw_byte_t mask_bc_reg;
   prw_byte_t pwr0_reg;
   prw_byte_t pwr2_reg;
   prw_byte_t test_en_reg;
   prw_byte_t page_reg;
   prw_byte_t map_reg;
   prw_byte_t rd_next;
   logic      wr_en;
   logic      rd_en;
   prw_byte_t pin_in_arr [4];

   assign wr_en = ce_in && window_select_in && req_in.wr;
   assign rd_en = ce_in && window_select_in && req_in.rd;

   // pin and status synchronisers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pins_meta_reg <= '0;
         pins_sync_reg <= '0;
         for (int i = 0; i < 3; i++) begin
            imc_meta_reg[i] <= `PRW_RST_BYTE;
            imc_sync_reg[i] <= `PRW_RST_BYTE;
         end
         for (int i = 0; i < 2; i++) begin
            prot_meta_reg[i] <= `PRW_RST_BYTE;
            prot_sync_reg[i] <= `PRW_RST_BYTE;
         end
      end else if (ce_in) begin
         pins_meta_reg    <= pins_in;
         pins_sync_reg    <= pins_meta_reg;
         imc_meta_reg[0]  <= input_cells_a_in;
         imc_meta_reg[1]  <= input_cells_b_in;
         imc_meta_reg[2]  <= input_cells_c_in;
         prot_meta_reg[0] <= main_protect_in;
         prot_meta_reg[1] <= secondary_protect_in;
         imc_sync_reg     <= imc_meta_reg;
         prot_sync_reg    <= prot_meta_reg;
      end
   end

   assign pin_in_arr[0] = pins_sync_reg.in_a;
   assign pin_in_arr[1] = pins_sync_reg.in_b;
   assign pin_in_arr[2] = pins_sync_reg.in_c;
   assign pin_in_arr[3] = pins_sync_reg.in_d;

   // port configuration registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < 4; i++) begin
            out_reg[i] <= `PRW_RST_BYTE;
            dir_reg[i] <= `PRW_RST_BYTE;
            drv_reg[i] <= `PRW_RST_BYTE;
         end
         mode_reg[0] <= `PRW_RST_BYTE;
         mode_reg[1] <= `PRW_RST_BYTE;
      end else if (wr_en) begin
         unique case (req_in.ofs)
            `PRW_OFS_OUT_A:  out_reg[0]  <= req_in.wdata;
            `PRW_OFS_OUT_B:  out_reg[1]  <= req_in.wdata;
            `PRW_OFS_OUT_C:  out_reg[2]  <= req_in.wdata;
            `PRW_OFS_OUT_D:  out_reg[3]  <= req_in.wdata;
            `PRW_OFS_DIR_A:  dir_reg[0]  <= req_in.wdata;
            `PRW_OFS_DIR_B:  dir_reg[1]  <= req_in.wdata;
            `PRW_OFS_DIR_C:  dir_reg[2]  <= req_in.wdata;
            `PRW_OFS_DIR_D:  dir_reg[3]  <= req_in.wdata;
            `PRW_OFS_DRV_A:  drv_reg[0]  <= req_in.wdata;
            `PRW_OFS_DRV_B:  drv_reg[1]  <= req_in.wdata;
            `PRW_OFS_DRV_C:  drv_reg[2]  <= req_in.wdata;
            `PRW_OFS_DRV_D:  drv_reg[3]  <= req_in.wdata;
            `PRW_OFS_MODE_A: mode_reg[0] <= req_in.wdata;
            `PRW_OFS_MODE_B: mode_reg[1] <= req_in.wdata;
            default: ;
         endcase
      end
   end

   // system registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mask_ab_reg <= `PRW_RST_BYTE;
         mask_bc_reg <= `PRW_RST_BYTE;
         pwr0_reg    <= `PRW_RST_BYTE;
         pwr2_reg    <= `PRW_RST_BYTE;
         test_en_reg <= `PRW_RST_BYTE;
         page_reg    <= `PRW_RST_BYTE;
         map_reg     <= `PRW_RST_BYTE;
      end else if (wr_en) begin
         unique case (req_in.ofs)
            `PRW_OFS_MASK_AB: mask_ab_reg <= req_in.wdata;
            `PRW_OFS_MASK_BC: mask_bc_reg <= req_in.wdata;
            `PRW_OFS_PWR0:    pwr0_reg    <= req_in.wdata;
            `PRW_OFS_PWR2:    pwr2_reg    <= req_in.wdata;
            `PRW_OFS_TEST_EN: test_en_reg <= req_in.wdata;
            `PRW_OFS_PAGE:    page_reg    <= req_in.wdata;
            `PRW_OFS_MAP:     map_reg     <= req_in.wdata;
            default: ;
         endcase
      end
   end

   // output cells: bus load beats logic update, masked bits keep value on a bus load
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         omc_ab_reg <= `PRW_RST_BYTE;
         omc_bc_reg <= `PRW_RST_BYTE;
      end else if (ce_in) begin
         if (wr_en && req_in.ofs == `PRW_OFS_OMC_AB) begin
            omc_ab_reg <= (omc_ab_reg & mask_ab_reg) | (req_in.wdata & ~mask_ab_reg);
         end else if (cells_clock_in && pwr0_reg[`PRW_PWR0_SPEED]) begin
            omc_ab_reg <= cells_next_ab_in;
         end
         if (wr_en && req_in.ofs == `PRW_OFS_OMC_BC) begin
            omc_bc_reg <= (omc_bc_reg & mask_bc_reg) | (req_in.wdata & ~mask_bc_reg);
         end else if (cells_clock_in && pwr0_reg[`PRW_PWR0_SPEED]) begin
            omc_bc_reg <= cells_next_bc_in;
         end
      end
   end

   // read mux
   always_comb begin
      rd_next = `PRW_UNMAPPED_RD;
      unique case (req_in.ofs)
         `PRW_OFS_IN_A:      rd_next = pin_in_arr[0];
         `PRW_OFS_IN_B:      rd_next = pin_in_arr[1];
         `PRW_OFS_IN_C:      rd_next = pin_in_arr[2];
         `PRW_OFS_IN_D:      rd_next = pin_in_arr[3];
         `PRW_OFS_MODE_A:    rd_next = mode_reg[0];
         `PRW_OFS_MODE_B:    rd_next = mode_reg[1];
         `PRW_OFS_OUT_A:     rd_next = out_reg[0];
         `PRW_OFS_OUT_B:     rd_next = out_reg[1];
         `PRW_OFS_OUT_C:     rd_next = out_reg[2];
         `PRW_OFS_OUT_D:     rd_next = out_reg[3];
         `PRW_OFS_DIR_A:     rd_next = dir_reg[0];
         `PRW_OFS_DIR_B:     rd_next = dir_reg[1];
         `PRW_OFS_DIR_C:     rd_next = dir_reg[2];
         `PRW_OFS_DIR_D:     rd_next = dir_reg[3];
         `PRW_OFS_DRV_A:     rd_next = drv_reg[0];
         `PRW_OFS_DRV_B:     rd_next = drv_reg[1];
         `PRW_OFS_DRV_C:     rd_next = drv_reg[2];
         `PRW_OFS_DRV_D:     rd_next = drv_reg[3];
         `PRW_OFS_IMC_A:     rd_next = imc_sync_reg[0];
         `PRW_OFS_IMC_B:     rd_next = imc_sync_reg[1];
         `PRW_OFS_IMC_C:     rd_next = imc_sync_reg[2];
         `PRW_OFS_OE_A:      rd_next = pin_oe_n_out[7:0] ^ 8'hff;
         `PRW_OFS_OE_B:      rd_next = pin_oe_n_out[15:8] ^ 8'hff;
         `PRW_OFS_OE_C:      rd_next = pin_oe_n_out[23:16] ^ 8'hff;
         `PRW_OFS_OE_D:      rd_next = pin_oe_n_out[31:24] ^ 8'hff;
         `PRW_OFS_OMC_AB:    rd_next = omc_ab_reg;
         `PRW_OFS_OMC_BC:    rd_next = omc_bc_reg;
         `PRW_OFS_MASK_AB:   rd_next = mask_ab_reg;
         `PRW_OFS_MASK_BC:   rd_next = mask_bc_reg;
         `PRW_OFS_PWR0:      rd_next = pwr0_reg;
         `PRW_OFS_PWR2:      rd_next = pwr2_reg;
         `PRW_OFS_PROT_MAIN: rd_next = prot_sync_reg[0];
         `PRW_OFS_PROT_SEC:  rd_next = prot_sync_reg[1];
         `PRW_OFS_TEST_EN:   rd_next = test_en_reg;
         `PRW_OFS_PAGE:      rd_next = page_reg;
         `PRW_OFS_MAP:       rd_next = map_reg;
         default:            rd_next = `PRW_UNMAPPED_RD;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out       <= `PRW_RST_BYTE;
         rdata_valid_out <= 1'b0;
      end else if (ce_in) begin
         rdata_valid_out <= rd_en;
         if (rd_en) begin
            rdata_out <= rd_next;
         end
      end
   end

   // pin drivers, one generate per port
   for (genvar p = 0; p < `PRW_NUM_PORTS; p++) begin : g_port
      prw_byte_t drive_val;
      if (p < 2) begin : g_addr
         always_comb begin
            for (int b = 0; b < 8; b++) begin
               if (mode_reg[p][b]) begin
                  drive_val[b] = latched_addr_in[b];
               end else begin
                  drive_val[b] = out_reg[p][b];
               end
            end
         end
      end else begin : g_plain
         assign drive_val = out_reg[p];
      end
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            pin_out[p*8 +: 8]            <= `PRW_RST_BYTE;
            pin_oe_n_out[p*8 +: 8]       <= 8'hff;
            pin_drive_type_out[p*8 +: 8] <= `PRW_RST_BYTE;
         end else if (ce_in) begin
            pin_out[p*8 +: 8]            <= drive_val;
            pin_oe_n_out[p*8 +: 8]       <= ~dir_reg[p];
            pin_drive_type_out[p*8 +: 8] <= drv_reg[p];
         end
      end
   end

   // system control outputs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cells_ab_out         <= `PRW_RST_BYTE;
         cells_bc_out         <= `PRW_RST_BYTE;
         array_sleep_out      <= 1'b1;
         power_second_out     <= `PRW_RST_BYTE;
         test_port_enable_out <= `PRW_RST_BYTE;
         page_out             <= `PRW_RST_BYTE;
         memory_space_map_out <= `PRW_RST_BYTE;
      end else if (ce_in) begin
         cells_ab_out         <= omc_ab_reg;
         cells_bc_out         <= omc_bc_reg;
         array_sleep_out      <= ~pwr0_reg[`PRW_PWR0_SPEED];
         power_second_out     <= pwr2_reg;
         test_port_enable_out <= test_en_reg;
         page_out             <= page_reg;
         memory_space_map_out <= map_reg;
      end
   end
endmodule // prw_port_window

//--- tb/prw_port_window_monitor.sv
module prw_window_monitor (
   // clock and reset
   input wire logic               clk_in,
   input wire logic               rst_in,
   input wire logic               ce_in,
   // bus
   input wire logic               window_select_in,
   input wire prw_pkg::prw_req_s  req_in,
   input wire prw_pkg::prw_byte_t main_protect_in,
   input wire logic [7:0]         rdata_out,
   input wire logic               rdata_valid_out,
   // controls
   input wire logic [31:0]        pin_oe_n_out,
   input wire logic [31:0]        pin_drive_type_out,
   input wire logic               array_sleep_out,
   input wire logic [7:0]         memory_space_map_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import prw_pkg::*;
   logic       acc_rd;
   logic       acc_wr;
   logic [1:0] age_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   assign acc_rd = ce_in && window_select_in && req_in.rd;
   assign acc_wr = ce_in && window_select_in && req_in.wr;
   // cycles since reset, so the synchronisers hold real pin history
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) age_reg <= 2'h0;
      else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
   end
   property p_rd_answer; acc_rd |=> rdata_valid_out; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_no_answer; !acc_rd |=> !rdata_valid_out; endproperty
   a_no_answer: assert property (p_no_answer) else $error("stray read valid");
   property p_unmapped;
      acc_rd && req_in.ofs inside {[8'h24:8'haf]} |=> rdata_out == 8'hff;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("empty offset read");
   property p_protect;
      acc_rd && req_in.ofs == 8'hc0 && age_reg == 2'h3 && $past(ce_in) && $past(ce_in, 2)
         && $stable(main_protect_in) && $past(main_protect_in, 2) == main_protect_in
         |=> rdata_out == $past(main_protect_in);
   endproperty
   a_protect: assert property (p_protect) else $error("protect status read");
   property p_dir_oe;
      acc_wr && req_in.ofs == 8'h06 ##1 ce_in |=> pin_oe_n_out[7:0] == ~$past(req_in.wdata, 2);
   endproperty
   a_dir_oe: assert property (p_dir_oe) else $error("direction not on enables");
   property p_drv;
      acc_wr && req_in.ofs == 8'h16 ##1 ce_in
         |=> pin_drive_type_out[23:16] == $past(req_in.wdata, 2);
   endproperty
   a_drv: assert property (p_drv) else $error("driver type not applied");
   property p_map;
      acc_wr && req_in.ofs == 8'he2 ##1 ce_in |=> memory_space_map_out == $past(req_in.wdata, 2);
   endproperty
   a_map: assert property (p_map) else $error("memory map not applied");
   property p_sleep;
      acc_wr && req_in.ofs == 8'hb0 ##1 ce_in |=> array_sleep_out != $past(req_in.wdata[3], 2);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not following speed bit");
   property p_enout;
      acc_rd && req_in.ofs == 8'h0c |=> rdata_out == ~$past(pin_oe_n_out[7:0]);
   endproperty
   a_enout: assert property (p_enout) else $error("enable state read");
   c_prot: cover property (acc_rd && req_in.ofs == 8'hc0);
   c_cells: cover property (acc_wr && req_in.ofs == 8'h20);
   c_empty: cover property (acc_rd && req_in.ofs == 8'hff);
endmodule // prw_window_monitor

bind prw_port_window prw_window_monitor u_mon (
   .clk_in, .rst_in, .ce_in, .window_select_in, .req_in, .main_protect_in, .rdata_out,
   .rdata_valid_out, .pin_oe_n_out, .pin_drive_type_out, .array_sleep_out, .memory_space_map_out
);

//--- tb/prw_mcu_model.sv
module prw_mcu_model (
   // bus clock
   input  wire logic         clk_in,
   // register window requests
   output logic              window_select_out,
   output prw_pkg::prw_req_s req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import prw_pkg::*;
   initial begin
      window_select_out = 1'b0;
      req_out = '0;
   end
   // request held from a falling edge over the taking edge, offset inside the window
   task automatic cyc(input logic rd, input logic wr, input prw_byte_t ofs, input prw_byte_t wd);
      @(negedge clk_in);
      window_select_out = 1'b1;
      req_out = '{rd: rd, wr: wr, ofs: ofs, wdata: wd};
      @(posedge clk_in);
   endtask
   // released bus shows inverted values, never the last ones
   task automatic idle;
      @(negedge clk_in);
      window_select_out = 1'b0;
      req_out = '{rd: 1'b0, wr: 1'b0, ofs: ~req_out.ofs, wdata: ~req_out.wdata};
   endtask
endmodule // prw_mcu_model

//--- tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import prw_pkg::*;
   logic        clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, cells_clock_in = 1'b0;
   logic        window_select_in, rdata_valid_out, array_sleep_out;
   prw_req_s    req_in;
   prw_pins_s   pins_in;
   prw_byte_t   latched_addr_in, input_cells_a_in, input_cells_b_in, input_cells_c_in;
   prw_byte_t   main_protect_in, secondary_protect_in, cells_next_ab_in, cells_next_bc_in;
   logic [7:0]  rdata_out, cells_ab_out, cells_bc_out, power_second_out;
   logic [7:0]  test_port_enable_out, page_out, memory_space_map_out;
   logic [31:0] pin_out, pin_oe_n_out, pin_drive_type_out;
   prw_byte_t   exp_q[$];
   prw_byte_t   wv[23];
   prw_byte_t   ro_exp[9];
   prw_byte_t   rw_tab[23] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h20, 8'h21, 8'h22, 8'h23, 8'hb0, 8'hb4,
      8'hc7, 8'he0, 8'he2};
   prw_byte_t   ro_ofs[9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0a, 8'h0b, 8'h18, 8'hc0, 8'hc2};
   prw_byte_t   un_tab[8] = '{8'h0e, 8'h0f, 8'h19, 8'h1c, 8'h24, 8'h80, 8'hc1, 8'hff};
   int          di[4] = '{4, 5, 10, 11};
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc_n = 0;
   int          seed = 55660;
   prw_byte_t   v;

   always #4 clk_in = ~clk_in;

   prw_port_window u_dut (
      .clk_in, .rst_in, .ce_in, .window_select_in, .req_in, .latched_addr_in, .rdata_out,
      .rdata_valid_out, .pins_in, .input_cells_a_in, .input_cells_b_in, .input_cells_c_in,
      .main_protect_in, .secondary_protect_in, .cells_next_ab_in, .cells_next_bc_in,
      .cells_clock_in, .pin_out, .pin_oe_n_out, .pin_drive_type_out, .cells_ab_out,
      .cells_bc_out, .array_sleep_out, .power_second_out, .test_port_enable_out, .page_out,
      .memory_space_map_out
   );
   prw_mcu_model u_mcu (.clk_in, .window_select_out(window_select_in), .req_out(req_in));

   task automatic check(input prw_byte_t seen, input prw_byte_t exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input prw_byte_t o, input prw_byte_t d);
      u_mcu.cyc(1'b0, 1'b1, o, d);
   endtask
   task automatic rd(input prw_byte_t o, input prw_byte_t e);
      exp_q.push_back(e);
      u_mcu.cyc(1'b1, 1'b0, o, 8'h00);
   endtask
   task automatic settle;
      u_mcu.idle();
      repeat (2) @(negedge clk_in);
   endtask
   task automatic rand_in;
      pins_in = prw_pins_s'($random(seed));
      {latched_addr_in, input_cells_a_in, input_cells_b_in, input_cells_c_in} = $random(seed);
      {main_protect_in, secondary_protect_in, cells_next_ab_in, cells_next_bc_in} = $random(seed);
   endtask

   // read results against the oldest noted expectation, plus hang limit
   always @(negedge clk_in) begin
      cyc_n++;
      if (cyc_n == 2000) begin
         n_fail++;
         give_verdict();
      end else if (rdata_valid_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, rdata_out, 8'h00);
         end else check(rdata_out, exp_q.pop_front());
      end
   end

   initial begin
      rand_in();
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      for (int i = 0; i < 4; i++) check(pin_oe_n_out[i*8 +: 8], 8'hff);
      check({7'h00, array_sleep_out}, 8'h01);
      foreach (rw_tab[i]) rd(rw_tab[i], 8'h00);
      foreach (rw_tab[i]) begin
         wv[i] = prw_byte_t'($random(seed));
         wr(rw_tab[i], wv[i]);
      end
      foreach (rw_tab[i]) rd(rw_tab[i], wv[i]);
      for (int i = 0; i < 4; i++) rd((i < 2) ? 8'h0c + 8'(i) : 8'h18 + 8'(i), wv[di[i]]);
      settle();
      for (int i = 0; i < 4; i++) begin
         check(pin_oe_n_out[i*8 +: 8], ~wv[di[i]]);
         check(pin_drive_type_out[i*8 +: 8], wv[di[i] + 2]);
      end
      check(power_second_out, wv[19]);
      check(test_port_enable_out, wv[20]);
      check(page_out, wv[21]);
      check(memory_space_map_out, wv[22]);
      check({7'h00, array_sleep_out}, {7'h00, ~wv[18][3]});
      rand_in();
      repeat (3) @(negedge clk_in);
      ro_exp = '{pins_in.in_a, pins_in.in_b, pins_in.in_c, pins_in.in_d, input_cells_a_in,
         input_cells_b_in, input_cells_c_in, main_protect_in, secondary_protect_in};
      foreach (ro_ofs[i]) wr(ro_ofs[i], ~ro_exp[i]);
      foreach (ro_ofs[i]) rd(ro_ofs[i], ro_exp[i]);
      v = prw_byte_t'($random(seed));
      wr(8'h02, 8'h0f);
      wr(8'h03, 8'hff);
      wr(8'h04, v);
      settle();
      check(pin_out[7:0], {v[7:4], latched_addr_in[3:0]});
      check(pin_out[15:8], latched_addr_in);
      wr(8'h02, 8'h00);
      settle();
      check(pin_out[7:0], v);
      // clock enable low: a write must leave state untouched
      ce_in = 1'b0;
      wr(8'h04, ~v);
      settle();
      ce_in = 1'b1;
      check(pin_out[7:0], v);
      rd(8'h04, v);
      wr(8'h22, 8'h00);
      wr(8'h20, 8'h00);
      wr(8'h22, 8'h0f);
      wr(8'h20, 8'hff);
      wr(8'h23, 8'h00);
      wr(8'h21, 8'ha5);
      wr(8'h23, 8'hf0);
      wr(8'h21, 8'h5a);
      rd(8'h20, 8'hf0);
      rd(8'h21, 8'haa);
      wr(8'h22, 8'h00);
      wr(8'hb0, 8'h08);
      settle();
      check(cells_ab_out, 8'hf0);
      check(cells_bc_out, 8'haa);
      cells_clock_in = 1'b1;
      @(negedge clk_in);
      cells_clock_in = 1'b0;
      v = cells_next_ab_in;
      rd(8'h20, v);
      rd(8'h21, cells_next_bc_in);
      wr(8'hb0, 8'h00);
      settle();
      check({7'h00, array_sleep_out}, 8'h01);
      cells_next_ab_in = ~v;
      cells_clock_in = 1'b1;
      @(negedge clk_in);
      cells_clock_in = 1'b0;
      rd(8'h20, v);
      foreach (un_tab[i]) wr(un_tab[i], 8'h00);
      foreach (un_tab[i]) rd(un_tab[i], 8'hff);
      rd(8'he0, wv[21]);
      rd(8'he2, wv[22]);
      settle();
      repeat (2) @(negedge clk_in);
      if (exp_q.size() != 0) n_fail++;
      give_verdict();
   end
endmodule // tb_top
